// >>> verilog/lfc_config_regs.sv
/*
  Line feed configuration register bank with its debounce filter and
  power readout selection.
  Assumes a single-cycle register port driven synchronously to clock_i;
  read data appear the cycle after the read strobe.
*/
`timescale 1ns/10ps

// Overview of operation
// - Debounce count sets ring trip steady time
// - Three-bit code selects loop current
// - Bit six sets on-hook polarity
// - Six-bit on-hook magnitude, 1.5 V steps
// - Six-bit common mode voltage code
// - Six-bit high battery target code
// - Six-bit low battery target code
// - Pointer selects one of six transistors
// - Selected transistor power shown in readout
// - Readout is eight-bit real-time value
// - Ring trip flag shows debounced result
module lfc_config_regs
  import lfc_pkg::*;
#(
  parameter int STEP_CYCLES = LFC_STEP_CYCLES,
  parameter int PWR_W = 8
)
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [7:0] rdata_o,
  input wire logic ring_trip_raw_i,
  input wire logic [LFC_NUM_XTOR*PWR_W-1:0] power_samples_i,
  output logic [LFC_DEBOUNCE_W-1:0] ring_trip_debounce_count_o,
  output logic [LFC_CURRENT_W-1:0] loop_current_code_o,
  output logic onhook_polarity_o,
  output logic [LFC_VOLT_W-1:0] onhook_voltage_code_o,
  output logic [LFC_VOLT_W-1:0] common_mode_code_o,
  output logic [LFC_VOLT_W-1:0] high_battery_code_o,
  output logic [LFC_VOLT_W-1:0] low_battery_code_o,
  output logic [LFC_PTR_W-1:0] power_select_pointer_o,
  output logic [PWR_W-1:0] power_readout_o,
  output logic ring_trip_flag_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [LFC_DEBOUNCE_W-1:0] debounce;
    logic [LFC_CURRENT_W-1:0] current;
    logic polarity;
    logic [LFC_VOLT_W-1:0] onhook;
    logic [LFC_VOLT_W-1:0] common;
    logic [LFC_VOLT_W-1:0] high_bat;
    logic [LFC_VOLT_W-1:0] low_bat;
    logic [LFC_PTR_W-1:0] pointer;
    logic [7:0] rdata;
  } lfc_regs_state_type;

  lfc_regs_state_type state_q;
  lfc_regs_state_type state_d;

  logic flag_w;
  logic [PWR_W-1:0] power_w;

  // ==========================================================
  // Debounce filter
  // filter uses interval
  lfc_debounce #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_debounce (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .raw_i(ring_trip_raw_i),
    .interval_i(state_q.debounce),
    .filtered_o(flag_w)
  );

  // ==========================================================
  // Power readout selection
  // pointer drives readout
  lfc_power_mux #(
    .WIDTH(PWR_W)
  ) u_power_mux (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .power_select_pointer_i(state_q.pointer),
    .power_samples_i(power_samples_i),
    .power_readout_o(power_w)
  );

  // ==========================================================
  // Register writes and reads
  always_comb
  begin
    state_d = state_q;
    state_d.rdata = 8'h00;
    if (write_i)
    begin
      if (addr_i == LFC_ADDR_DEBOUNCE)
      begin
        state_d.debounce = wdata_i[LFC_DEBOUNCE_W-1:0];
      end
      else if (addr_i == LFC_ADDR_CURRENT)
      begin
        state_d.current = wdata_i[LFC_CURRENT_W-1:0];
      end
      else if (addr_i == LFC_ADDR_ONHOOK)
      begin
        state_d.polarity = wdata_i[LFC_POLARITY_BIT];
        state_d.onhook = wdata_i[LFC_VOLT_W-1:0];
      end
      else if (addr_i == LFC_ADDR_COMMON)
      begin
        state_d.common = wdata_i[LFC_VOLT_W-1:0];
      end
      else if (addr_i == LFC_ADDR_HIGH_BAT)
      begin
        // Ordering against the low battery is left to software.
        state_d.high_bat = wdata_i[LFC_VOLT_W-1:0];
      end
      else if (addr_i == LFC_ADDR_LOW_BAT)
      begin
        state_d.low_bat = wdata_i[LFC_VOLT_W-1:0];
      end
      else if (addr_i == LFC_ADDR_PWR_SEL)
      begin
        state_d.pointer = wdata_i[LFC_PTR_W-1:0];
      end
    end
    if (read_i)
    begin
      if (addr_i == LFC_ADDR_DEBOUNCE)
      begin
        state_d.rdata = {1'b0, state_q.debounce};
      end
      else if (addr_i == LFC_ADDR_CURRENT)
      begin
        state_d.rdata = {5'h00, state_q.current};
      end
      else if (addr_i == LFC_ADDR_ONHOOK)
      begin
        state_d.rdata = {1'b0, state_q.polarity, state_q.onhook};
      end
      else if (addr_i == LFC_ADDR_COMMON)
      begin
        state_d.rdata = {2'h0, state_q.common};
      end
      else if (addr_i == LFC_ADDR_HIGH_BAT)
      begin
        state_d.rdata = {2'h0, state_q.high_bat};
      end
      else if (addr_i == LFC_ADDR_LOW_BAT)
      begin
        state_d.rdata = {2'h0, state_q.low_bat};
      end
      else if (addr_i == LFC_ADDR_PWR_SEL)
      begin
        state_d.rdata = {5'h00, state_q.pointer};
      end
      else if (addr_i == LFC_ADDR_PWR_READ)
      begin
        state_d.rdata = 8'(power_w);
      end
      else if (addr_i == LFC_ADDR_STATUS)
      begin
        state_d.rdata = 8'h00;
        state_d.rdata[LFC_RING_FLAG_BIT] = flag_w;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q.debounce <= LFC_RST_DEBOUNCE;
      state_q.current <= LFC_RST_CURRENT;
      state_q.polarity <= LFC_RST_POLARITY;
      state_q.onhook <= LFC_RST_ONHOOK;
      state_q.common <= LFC_RST_COMMON;
      state_q.high_bat <= LFC_RST_HIGH_BAT;
      state_q.low_bat <= LFC_RST_LOW_BAT;
      state_q.pointer <= LFC_RST_PTR;
      state_q.rdata <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign rdata_o = state_q.rdata;
  assign ring_trip_debounce_count_o = state_q.debounce;
  assign loop_current_code_o = state_q.current;
  assign onhook_polarity_o = state_q.polarity;
  assign onhook_voltage_code_o = state_q.onhook;
  assign common_mode_code_o = state_q.common;
  assign high_battery_code_o = state_q.high_bat;
  assign low_battery_code_o = state_q.low_bat;
  assign power_select_pointer_o = state_q.pointer;
  assign power_readout_o = power_w;
  assign ring_trip_flag_o = flag_w;

endmodule : lfc_config_regs

// >>> common/lfc_pkg.sv
/*
  Package for the line feed configuration register bank: register
  offsets, field widths, reset values and timing constants.
  Assumes an eight-bit register port; the status and readout offsets
  are local choices.
*/
package lfc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] LFC_ADDR_DEBOUNCE = 8'h46;
  localparam logic [7:0] LFC_ADDR_CURRENT = 8'h47;
  localparam logic [7:0] LFC_ADDR_ONHOOK = 8'h48;
  localparam logic [7:0] LFC_ADDR_COMMON = 8'h49;
  localparam logic [7:0] LFC_ADDR_HIGH_BAT = 8'h4A;
  localparam logic [7:0] LFC_ADDR_LOW_BAT = 8'h4B;
  localparam logic [7:0] LFC_ADDR_PWR_SEL = 8'h4C;
  localparam logic [7:0] LFC_ADDR_PWR_READ = 8'h4D;
  localparam logic [7:0] LFC_ADDR_STATUS = 8'h44;

  // ==========================================================
  // Field widths and positions
  localparam int LFC_DEBOUNCE_W = 7;
  localparam int LFC_CURRENT_W = 3;
  localparam int LFC_VOLT_W = 6;
  localparam int LFC_PTR_W = 3;
  localparam int LFC_POLARITY_BIT = 6;
  localparam int LFC_RING_FLAG_BIT = 1;
  localparam int LFC_NUM_XTOR = 6;

  // ==========================================================
  // Reset values
  localparam logic [6:0] LFC_RST_DEBOUNCE = 7'h0A;
  localparam logic [2:0] LFC_RST_CURRENT = 3'h0;
  localparam logic [5:0] LFC_RST_ONHOOK = 6'h20;
  localparam logic LFC_RST_POLARITY = 1'h0;
  localparam logic [5:0] LFC_RST_COMMON = 6'h02;
  localparam logic [5:0] LFC_RST_HIGH_BAT = 6'h32;
  localparam logic [5:0] LFC_RST_LOW_BAT = 6'h10;
  localparam logic [2:0] LFC_RST_PTR = 3'h0;
  localparam logic [2:0] LFC_PTR_LAST = 3'h5;

  // ==========================================================
  // Timing: one debounce count is 1.25 ms
  localparam real LFC_CLK_NS = 5.0;
  localparam real LFC_DEBOUNCE_STEP_MS = 1.25;
  localparam int LFC_STEP_CYCLES =
    int'(LFC_DEBOUNCE_STEP_MS * 1.0e6 / LFC_CLK_NS);

endpackage : lfc_pkg

// >>> verilog/lfc_power_mux.sv
/*
  Selects the power sample of one external transistor and registers it.
  Assumes power samples arrive as one packed vector, Q1 in the low byte.
*/
`timescale 1ns/10ps
module lfc_power_mux
  import lfc_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [LFC_PTR_W-1:0] power_select_pointer_i,
  input wire logic [LFC_NUM_XTOR*WIDTH-1:0] power_samples_i,
  output logic [WIDTH-1:0] power_readout_o
);

  typedef struct packed {
    logic [WIDTH-1:0] power;
  } lfc_mux_state_type;

  lfc_mux_state_type state_q;
  lfc_mux_state_type state_d;

  // ==========================================================
  // Selection
  always_comb
  begin
    state_d = state_q;
    // Undefined pointer codes read zero rather than a stale transistor.
    state_d.power = '0;
    if (power_select_pointer_i <= LFC_PTR_LAST)
    begin
      state_d.power = power_samples_i[power_select_pointer_i*WIDTH +: WIDTH];
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign power_readout_o = state_q.power;

endmodule : lfc_power_mux

// >>> verilog/lfc_debounce.sv
/*
  Ring trip debounce filter: the raw detect must stay steady for the
  programmed number of 1.25 ms steps before the filtered flag follows.
  Assumes the raw detect input is synchronous to clock_i.
*/
`timescale 1ns/10ps
module lfc_debounce
  import lfc_pkg::*;
#(
  parameter int STEP_CYCLES = LFC_STEP_CYCLES
)
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic raw_i,
  input wire logic [LFC_DEBOUNCE_W-1:0] interval_i,
  output logic filtered_o
);

  typedef struct packed {
    logic [31:0] tick;
    logic [LFC_DEBOUNCE_W-1:0] steps;
    logic last_raw;
    logic filtered;
  } lfc_deb_state_type;

  lfc_deb_state_type state_q;
  lfc_deb_state_type state_d;

  // ==========================================================
  // Filter
  always_comb
  begin
    state_d = state_q;
    state_d.last_raw = raw_i;
    if (raw_i != state_q.last_raw || raw_i == state_q.filtered)
    begin
      state_d.tick = '0;
      state_d.steps = '0;
    end
    else if (state_q.steps >= interval_i)
    begin
      state_d.filtered = raw_i;
      state_d.tick = '0;
      state_d.steps = '0;
    end
    else if (state_q.tick == 32'(STEP_CYCLES - 1))
    begin
      state_d.tick = '0;
      state_d.steps = state_q.steps + 7'h01;
    end
    else
    begin
      state_d.tick = state_q.tick + 32'h00000001;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign filtered_o = state_q.filtered;

endmodule : lfc_debounce

// >>> dv/lfc_config_regs_monitor.sv
/*
  Checker on the ports of the line feed register bank.
  Assumes one clock domain and the single-cycle register port.
*/
`timescale 1ns/10ps
module lfc_config_regs_monitor
  import lfc_pkg::*;
#(
  parameter int STEP_CYCLES = LFC_STEP_CYCLES,
  parameter int PWR_W = 8
)
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic [7:0] rdata_o,
  input wire logic ring_trip_raw_i,
  input wire logic [LFC_NUM_XTOR*PWR_W-1:0] power_samples_i,
  input wire logic [LFC_DEBOUNCE_W-1:0] ring_trip_debounce_count_o,
  input wire logic [LFC_CURRENT_W-1:0] loop_current_code_o,
  input wire logic onhook_polarity_o,
  input wire logic [LFC_VOLT_W-1:0] onhook_voltage_code_o,
  input wire logic [LFC_VOLT_W-1:0] common_mode_code_o,
  input wire logic [LFC_VOLT_W-1:0] high_battery_code_o,
  input wire logic [LFC_VOLT_W-1:0] low_battery_code_o,
  input wire logic [LFC_PTR_W-1:0] power_select_pointer_o,
  input wire logic [PWR_W-1:0] power_readout_o,
  input wire logic ring_trip_flag_o
);
  // ==========================================================
  // Helpers
  // Undefined pointer codes must read as zero, never as stale data.
  logic [PWR_W-1:0] pick_w;
  assign pick_w = (power_select_pointer_o > LFC_PTR_LAST) ? '0 :
    power_samples_i[power_select_pointer_o*PWR_W +: PWR_W];

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  // ==========================================================
  // Properties
  // debounce field write
  property p_deb; write_i && addr_i == LFC_ADDR_DEBOUNCE |=>
    ring_trip_debounce_count_o == 7'($past(wdata_i)); endproperty
  a_deb: assert property (p_deb) else $error("debounce write lost");
  property p_cur; write_i && addr_i == LFC_ADDR_CURRENT |=>
    loop_current_code_o == 3'($past(wdata_i)); endproperty
  a_cur: assert property (p_cur) else $error("current write lost");
  property p_pol; write_i && addr_i == LFC_ADDR_ONHOOK |=>
    onhook_polarity_o == |($past(wdata_i) & 8'h40); endproperty
  a_pol: assert property (p_pol) else $error("polarity write lost");
  property p_ohv; write_i && addr_i == LFC_ADDR_ONHOOK |=>
    onhook_voltage_code_o == 6'($past(wdata_i)); endproperty
  a_ohv: assert property (p_ohv) else $error("on-hook write lost");
  property p_cm; write_i && addr_i == LFC_ADDR_COMMON |=>
    common_mode_code_o == 6'($past(wdata_i)); endproperty
  a_cm: assert property (p_cm) else $error("common write lost");
  property p_hb; write_i && addr_i == LFC_ADDR_HIGH_BAT |=>
    high_battery_code_o == 6'($past(wdata_i)); endproperty
  a_hb: assert property (p_hb) else $error("high bat write lost");
  property p_lb; write_i && addr_i == LFC_ADDR_LOW_BAT |=>
    low_battery_code_o == 6'($past(wdata_i)); endproperty
  a_lb: assert property (p_lb) else $error("low bat write lost");
  property p_ptr; write_i && addr_i == LFC_ADDR_PWR_SEL |=>
    power_select_pointer_o == 3'($past(wdata_i)); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer write lost");
  // readout follows pointer
  // The release edge is left out: the readout still shows reset there.
  property p_pwr; resetn_i |=> power_readout_o == $past(pick_w);
  endproperty
  a_pwr: assert property (p_pwr) else $error("readout wrong");
  property p_idle; !read_i |=> rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  // flag rises only on raw detect
  property p_flag; $rose(ring_trip_flag_o) |-> $past(ring_trip_raw_i);
  endproperty
  a_flag: assert property (p_flag) else $error("flag rose early");

  c_ptr: cover property (write_i && addr_i == LFC_ADDR_PWR_SEL);
  c_flag: cover property ($rose(ring_trip_flag_o));
  c_stat: cover property (read_i && addr_i == LFC_ADDR_STATUS);
endmodule : lfc_config_regs_monitor

bind lfc_config_regs lfc_config_regs_monitor #(
  .STEP_CYCLES(STEP_CYCLES), .PWR_W(PWR_W)) mon_u (
  .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
  .rdata_o(rdata_o), .ring_trip_raw_i(ring_trip_raw_i),
  .power_samples_i(power_samples_i),
  .ring_trip_debounce_count_o(ring_trip_debounce_count_o),
  .loop_current_code_o(loop_current_code_o),
  .onhook_polarity_o(onhook_polarity_o),
  .onhook_voltage_code_o(onhook_voltage_code_o),
  .common_mode_code_o(common_mode_code_o),
  .high_battery_code_o(high_battery_code_o),
  .low_battery_code_o(low_battery_code_o),
  .power_select_pointer_o(power_select_pointer_o),
  .power_readout_o(power_readout_o), .ring_trip_flag_o(ring_trip_flag_o));

// >>> dv/lfc_config_regs_tb.sv
/*
  Self-checking bench for the line feed register bank.
  Assumes the bank's single-clock port and a shortened debounce step.
*/
`timescale 1ns/10ps
module lfc_config_regs_tb;
  import lfc_pkg::*;
  localparam int STEP = 4;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic write_i = 1'b0;
  logic read_i = 1'b0;
  logic ring_trip_raw_i = 1'b0;
  logic [47:0] power_samples_i = 48'h0;
  logic [7:0] rdata_o;
  logic [7:0] power_readout_o;
  logic ring_trip_flag_o;
  logic [7:0] lfsr = 8'h4D;
  logic [7:0] model [7] = '{8'h0A, 8'h00, 8'h20, 8'h02, 8'h32, 8'h10, 8'h00};
  logic [7:0] got;
  logic [7:0] d;
  int fail_count = 0;
  int comparisons = 0;
  int i;
  int n;

  lfc_config_regs #(.STEP_CYCLES(STEP), .PWR_W(8)) dut_u (
    .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
    .rdata_o(rdata_o), .ring_trip_raw_i(ring_trip_raw_i),
    .power_samples_i(power_samples_i), .ring_trip_debounce_count_o(),
    .loop_current_code_o(), .onhook_polarity_o(),
    .onhook_voltage_code_o(), .common_mode_code_o(),
    .high_battery_code_o(), .low_battery_code_o(),
    .power_select_pointer_o(), .power_readout_o(power_readout_o),
    .ring_trip_flag_o(ring_trip_flag_o));

  initial
  begin
    forever #2.5 clock_i = ~clock_i;
  end

  // ==========================================================
  // Helpers
  function automatic logic [7:0] next_rand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : next_rand

  function automatic logic [7:0] field_mask(input int k);
    logic [7:0] m [7] = '{8'h7F, 8'h07, 8'h7F, 8'h3F, 8'h3F, 8'h3F, 8'h07};
    return m[k];
  endfunction : field_mask

  function automatic logic [7:0] pick(input int p, input logic [47:0] s);
    return (p > 5) ? 8'h00 : s[p*8 +: 8];
  endfunction : pick

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want)
    begin
      fail_count++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge clock_i);
  endtask : rd

  // A bounded wait: the flag must settle, or the run ends.
  task automatic wait_flag(input logic want, output int c);
    c = 0;
    while (ring_trip_flag_o !== want && c < 200)
    begin
      @(posedge clock_i);
      c++;
    end
    if (c >= 200)
    begin
      fail_count++;
      $display("ERROR %0t: flag wait timed out", $time);
      stop_test();
    end
  endtask : wait_flag

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    for (i = 0; i < 7; i++)
    begin
      rd(LFC_ADDR_DEBOUNCE + 8'(i), got);
      check(got, model[i]);
    end
    $display("test done: reset values");
    for (n = 0; n < 47; n++)
    begin
      i = (n < 7) ? n : int'(lfsr % 7);
      lfsr = next_rand(lfsr);
      d = (n < 7) ? 8'hFF : lfsr;
      if (i == 4) d = d | model[5];
      if (i == 5) d = d & (model[4] | 8'hC0);
      wr(LFC_ADDR_DEBOUNCE + 8'(i), d);
      model[i] = d & field_mask(i);
      rd(LFC_ADDR_DEBOUNCE + 8'(i), got);
      check(got, model[i]);
    end
    $display("test done: field write and read back");
    wr(8'h50, 8'hFF);
    rd(8'h50, got);
    check(got, 8'h00);
    wr(LFC_ADDR_STATUS, 8'hFF);
    rd(LFC_ADDR_STATUS, got);
    check(got, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      lfsr = next_rand(lfsr);
      power_samples_i <= {power_samples_i[39:0], lfsr};
      wr(LFC_ADDR_PWR_SEL, 8'(i) | 8'hF8);
      wr(LFC_ADDR_PWR_READ, 8'hA5);
      rd(LFC_ADDR_PWR_READ, got);
      check(got, pick(i, power_samples_i));
      check(power_readout_o, pick(i, power_samples_i));
    end
    $display("test done: power pointer");
    wr(LFC_ADDR_DEBOUNCE, 8'h01);
    ring_trip_raw_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    ring_trip_raw_i <= 1'b0;
    repeat (12) @(posedge clock_i);
    check(8'(ring_trip_flag_o), 8'h00);
    ring_trip_raw_i <= 1'b1;
    wait_flag(1'b1, n);
    check(8'(n >= STEP), 8'h01);
    rd(LFC_ADDR_STATUS, got);
    check(got, 8'h02);
    ring_trip_raw_i <= 1'b0;
    wait_flag(1'b0, n);
    check(8'(n >= STEP), 8'h01);
    $display("test done: ring trip debounce");
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(LFC_ADDR_HIGH_BAT, got);
    check(got, 8'h32);
    $display("test done: second reset");
    stop_test();
  end
endmodule : lfc_config_regs_tb
